// ---- logic/pgf_pkg.sv ----
// Functional notes
// RULE_01: falling power_ok edge sets regulator flag
// RULE_02: edge counts only while regulator enabled
// RULE_03: writing one clears the flag
// RULE_04: zero means no fall since clear
// RULE_05: all flags zero after reset
// RULE_06: mask zero passes, one blocks interrupt
// RULE_07: write zero keeps; set beats clear
package pgf_pkg;
	// ***************************************
	// register map
	// ***************************************
	localparam logic [7:0] STATUS_OFFS = 8'h3D;
	localparam logic [7:0] MASK_OFFS = 8'h3E;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'hFF;
	// bit layout: linreg4..1 at 7..4, buck4..1 at 3..0
	typedef struct packed {
		logic linreg4_pwrok_fall_flag;
		logic linreg3_pwrok_fall_flag;
		logic linreg2_pwrok_fall_flag;
		logic linreg1_pwrok_fall_flag;
		logic buck4_pwrok_fall_flag;
		logic buck3_pwrok_fall_flag;
		logic buck2_pwrok_fall_flag;
		logic buck1_pwrok_fall_flag;
	} pgf_flags_s;
	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pgf_req_s;
endpackage : pgf_pkg

// ---- logic/pgf_irq_status.sv ----
`timescale 1ns/1ps
module pgf_irq_status (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// regulator state, bit order as the status layout
	input wire logic [7:0] power_ok,
	input wire logic [7:0] reg_enable,
	// register port
	input wire pgf_pkg::pgf_req_s req,
	output logic [7:0] rdata,
	// interrupt
	output logic irq
);
	// ***************************************
	// state
	// ***************************************
	pgf_pkg::pgf_flags_s status_ff, nxt_status;
	logic [7:0] mask_ff, nxt_mask;
	logic [7:0] pok_ff, nxt_pok;
	logic [7:0] rdata_ff, nxt_rdata;
	logic irq_ff, nxt_irq;
	logic [7:0] fall;
	logic [7:0] clr;

	logic wr_status, wr_mask, rd_status, rd_mask;

	// ***************************************
	// helpers
	// ***************************************
	// true when a strobe hits the given register
	function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] offs);
		hit = strobe && (addr == offs);
	endfunction : hit

	// gated falling edge: high before, low now, regulator enabled
	function automatic logic [7:0] gated_fall(input logic [7:0] prev, input logic [7:0] now, input logic [7:0] en);
		gated_fall = prev & ~now & en;
	endfunction : gated_fall

	// write one clears, a new event sets, the set applied last
	function automatic logic [7:0] w1c_next(input logic [7:0] cur, input logic [7:0] clr_b, input logic [7:0] set_b);
		w1c_next = (cur & ~clr_b) | set_b;
	endfunction : w1c_next

	// any flag that its mask bit lets through
	function automatic logic pending(input logic [7:0] flags, input logic [7:0] msk);
		pending = |(flags & ~msk);
	endfunction : pending

	// ***************************************
	// address decode
	// ***************************************
	// a read and a write strobe per register, unmapped addresses hit nothing
	always_comb begin
		wr_status = hit(req.wr, req.addr, pgf_pkg::STATUS_OFFS);
		wr_mask = hit(req.wr, req.addr, pgf_pkg::MASK_OFFS);
		rd_status = hit(req.rd, req.addr, pgf_pkg::STATUS_OFFS);
		rd_mask = hit(req.rd, req.addr, pgf_pkg::MASK_OFFS);
	end

	// ***************************************
	// edge detection
	// ***************************************
	// previous power_ok sample and gated falls of this cycle
	always_comb begin
		nxt_pok = power_ok;
		fall = gated_fall(pok_ff, power_ok, reg_enable); // RULE_01 RULE_02
	end

	// history cleared in reset, so a low level gives no edge
	always_ff @(posedge clk) begin
		if (rst) begin
			pok_ff <= 8'h00;
		end else begin
			pok_ff <= nxt_pok;
		end
	end

	// ***************************************
	// status flags
	// ***************************************
	// write one clears, write zero keeps, a new fall wins
	always_comb begin
		clr = wr_status ? req.wdata : 8'h00; // RULE_03
		nxt_status = w1c_next(status_ff, clr, fall); // RULE_07
	end

	// sticky flags, zero after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			status_ff <= pgf_pkg::STATUS_RESET; // RULE_05
		end else begin
			status_ff <= nxt_status;
		end
	end

	// ***************************************
	// mask register
	// ***************************************
	// plain read and write register, all masked after reset
	always_comb begin
		nxt_mask = wr_mask ? req.wdata : mask_ff;
	end

	// mask storage
	always_ff @(posedge clk) begin
		if (rst) begin
			mask_ff <= pgf_pkg::MASK_RESET;
		end else begin
			mask_ff <= nxt_mask;
		end
	end

	// ***************************************
	// read data
	// ***************************************
	// data stand one cycle after the strobe, zero otherwise
	always_comb begin
		nxt_rdata = 8'h00;
		if (rd_status) begin
			nxt_rdata = status_ff; // RULE_04
		end else if (rd_mask) begin
			nxt_rdata = mask_ff;
		end
	end

	// read data register
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ***************************************
	// interrupt
	// ***************************************
	// level output follows the flags that the mask passes
	always_comb begin
		nxt_irq = pending(nxt_status, nxt_mask); // RULE_06
	end

	// interrupt register, so the pin comes from a flop
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	assign rdata = rdata_ff;
	assign irq = irq_ff;

	// ***************************************
	// checks
	// ***************************************
	// a gated fall on bit 0
	sequence s_fall0;
		pok_ff[0] && !power_ok[0] && reg_enable[0];
	endsequence

	// a clearing write on bit 3 with no fall of its own
	sequence s_clear3;
		wr_status && req.wdata[3] && !(pok_ff[3] && !power_ok[3] && reg_enable[3]);
	endsequence

	// a fall on bit 5 together with a clearing write
	sequence s_set_clear5;
		pok_ff[5] && !power_ok[5] && reg_enable[5] && wr_status && req.wdata[5];
	endsequence

	// status read strobe
	sequence s_read_status;
		req.rd && req.addr == pgf_pkg::STATUS_OFFS;
	endsequence

	// mask read strobe
	sequence s_read_mask;
		req.rd && req.addr == pgf_pkg::MASK_OFFS;
	endsequence

	// mask write strobe
	sequence s_write_mask;
		req.wr && req.addr == pgf_pkg::MASK_OFFS;
	endsequence

	// single bit fall sets its flag
	a_fall_sets: assert property (@(posedge clk) disable iff (rst) // RULE_01
		s_fall0 |=> status_ff[0]) else $error("fall did not set flag");

	// every gated fall sets its own flag
	a_all_falls: assert property (@(posedge clk) disable iff (rst) // RULE_01
		(status_ff & $past(pok_ff) & ~$past(power_ok) & $past(reg_enable))
		== ($past(pok_ff) & ~$past(power_ok) & $past(reg_enable))) else $error("fall lost");

	// disabled regulator never raises bit 7
	a_gate_enable: assert property (@(posedge clk) disable iff (rst) // RULE_02
		(!status_ff[7] && !reg_enable[7] && !(req.wr)) |=> !status_ff[7]) else $error("flag set while disabled");

	// no new flag on any disabled regulator
	a_gate_all: assert property (@(posedge clk) disable iff (rst) // RULE_02
		(status_ff & ~$past(status_ff) & ~$past(reg_enable)) == 8'h00) else $error("disabled flag set");

	// write one clears bit 3
	a_w1c_clear: assert property (@(posedge clk) disable iff (rst) // RULE_03
		s_clear3 |=> !status_ff[3]) else $error("write one did not clear");

	// write one clears every bit without a fall
	a_w1c_all: assert property (@(posedge clk) disable iff (rst) // RULE_03
		wr_status |=> (status_ff & $past(req.wdata) & ~($past(pok_ff) & ~$past(power_ok) & $past(reg_enable)))
		== 8'h00) else $error("clear lost");

	// zero flag stays zero without a fall
	a_zero_stays: assert property (@(posedge clk) disable iff (rst) // RULE_04
		(!status_ff[2] && !(pok_ff[2] && !power_ok[2])) |=> !status_ff[2]) else $error("flag set without fall");

	// no flag rises without a fall of its level
	a_no_spurious: assert property (@(posedge clk) disable iff (rst) // RULE_04
		(status_ff & ~$past(status_ff) & ~($past(pok_ff) & ~$past(power_ok))) == 8'h00)
		else $error("spurious flag");

	// flags zero after reset
	a_reset_zero: assert property (@(posedge clk) rst |=> status_ff == 8'h00) else $error("flags not zero"); // RULE_05

	// outputs idle after reset
	a_reset_out: assert property (@(posedge clk) rst |=> (!irq && rdata == 8'h00)) else $error("outputs busy"); // RULE_05

	// mask all set after reset
	a_reset_mask: assert property (@(posedge clk) rst |=> mask_ff == pgf_pkg::MASK_RESET)
		else $error("mask not set");

	// interrupt follows unmasked flags
	a_irq_mask: assert property (@(posedge clk) disable iff (rst) // RULE_06
		irq == pending(status_ff, mask_ff)) else $error("irq mismatch");

	// full mask keeps the pin low
	a_irq_masked: assert property (@(posedge clk) disable iff (rst) // RULE_06
		(mask_ff == 8'hFF) |-> !irq) else $error("irq through mask");

	// no flags, no interrupt
	a_irq_idle: assert property (@(posedge clk) disable iff (rst) // RULE_06
		(status_ff == 8'h00) |-> !irq) else $error("irq without flag");

	// new fall wins over a clear
	a_set_wins: assert property (@(posedge clk) disable iff (rst) // RULE_07
		s_set_clear5 |=> status_ff[5]) else $error("set lost to clear");

	// write zero keeps a set flag
	a_write_zero: assert property (@(posedge clk) disable iff (rst) // RULE_07
		(status_ff[1] && (!req.wr || !req.wdata[1])) |=> status_ff[1]) else $error("flag lost");

	// flags hold with no write and no fall
	a_status_hold: assert property (@(posedge clk) disable iff (rst) // RULE_07
		(!wr_status && !(|(pok_ff & ~power_ok & reg_enable))) |=> status_ff == $past(status_ff))
		else $error("flags moved");

	// status read returns the flags
	a_read_data: assert property (@(posedge clk) disable iff (rst) // RULE_04
		s_read_status |=> rdata == $past(status_ff)) else $error("read wrong");

	// mask read returns the mask
	a_read_mask: assert property (@(posedge clk) disable iff (rst)
		s_read_mask |=> rdata == $past(mask_ff)) else $error("mask read wrong");

	// mask write lands
	a_mask_write: assert property (@(posedge clk) disable iff (rst)
		s_write_mask |=> mask_ff == $past(req.wdata)) else $error("mask write lost");

	// mask holds without a write
	a_mask_hold: assert property (@(posedge clk) disable iff (rst)
		!wr_mask |=> mask_ff == $past(mask_ff)) else $error("mask moved");

	// read data zero outside the answer cycle
	a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
		!req.rd |=> rdata == 8'h00) else $error("rdata not idle");

	// unmapped reads return zero
	a_rdata_unmapped: assert property (@(posedge clk) disable iff (rst)
		(req.rd && !rd_status && !rd_mask) |=> rdata == 8'h00) else $error("unmapped read");
endmodule : pgf_irq_status

// ---- dv/pgf_host.sv ----
`timescale 1ns/1ps
module pgf_host (
	// bus side
	input wire logic clk,
	output pgf_pkg::pgf_req_s req
);
	initial req = '0;
	// one strobe cycle, then one idle cycle so calls never clash
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		req <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask : acc
endmodule : pgf_host

// ---- dv/tb_pgf_irq_status.sv ----
`timescale 1ns/1ps
module tb_pgf_irq_status;
	logic clk = 0, rst = 1, rv = 0, irq;
	logic [7:0] power_ok = 8'hFF, reg_enable = 8'h00, rdata, st = 8'h00, m;
	int unsigned x = 53003;
	int failures = 0, comparisons = 0;
	logic [7:0] q[$];
	pgf_pkg::pgf_req_s req;
	pgf_irq_status u_pgf_irq_status (.clk(clk), .rst(rst), .power_ok(power_ok), .reg_enable(reg_enable),
		.req(req), .rdata(rdata), .irq(irq));
	pgf_host u_pgf_host (.clk(clk), .req(req));
	initial forever #5 clk = ~clk;
	// compare and count
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	function automatic int unsigned xs(input int unsigned v);
		int unsigned t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction : xs
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		u_pgf_host.acc(0, a, 8'h00);
	endtask : rd
	task automatic test_done;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done
	// read data watcher, one cycle after the strobe
	always @(posedge clk) rv <= req.rd;
	always @(negedge clk) if (rv) chk("rdata", rdata, q.pop_front());
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(8'h3D, 8'h00);
		rd(8'h3E, 8'hFF);
		rd(8'h40, 8'h00);
		for (int i = 0; i < 8; i++) begin
			x = xs(x);
			reg_enable <= x[7:0];
			@(posedge clk);
			power_ok <= 8'h00;
			@(posedge clk);
			power_ok <= 8'hFF;
			st = st | x[7:0];
			u_pgf_host.acc(1, 8'h3D, 8'h00);
			rd(8'h3D, st);
			m = x[15:8];
			u_pgf_host.acc(1, 8'h3E, m);
			@(negedge clk);
			chk("irq", {7'h00, irq}, {7'h00, |(st & ~m)});
			@(posedge clk);
			u_pgf_host.acc(1, 8'h3D, x[23:16]);
			st = st & ~x[23:16];
			rd(8'h3D, st);
			$display("round %0d done", i);
		end
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(8'h3D, 8'h00);
		rd(8'h3E, 8'hFF);
		@(negedge clk);
		chk("irq", {7'h00, irq}, 8'h00);
		chk("queue", 8'(q.size()), 8'h00);
		$display("reset test done");
		test_done;
	end
endmodule : tb_pgf_irq_status
